// ===== sar_seq_consts.vh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef SAR_SEQ_CONSTS_VH
`define SAR_SEQ_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_CLKDIV 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0C
`define OFS_RESULT 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_EXT_BIT 0
`define CTRL_RES_LSB 8
`define CTRL_RES_MSB 12
`define ST_DONE_BIT 0
`define ST_WIDTH_BIT 1
`define RESULT_BUSY_BIT 16

// ****************************************************************
// Reset and conversion start values
// ****************************************************************
`define RES_FULL 5'h10
`define CLKDIV_RST 16'h006B
`define DATA_N_RST 16'hFFFF
`define SAR_INIT 16'h8000

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 5
`define BUSY_LAG_NS 20
`define PULSE_MIN_NS 100
`define PULSE_MAX_NS 700
`define STEPS_FULL 17
// Least times round up, longest times round down
`define BUSY_LAG_CYC ((`BUSY_LAG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_MIN_CYC ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_MAX_CYC (`PULSE_MAX_NS / `CLK_PERIOD_NS)

`endif

// ===== sync2.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sync2 #(
	parameter W = 2
) (
	input wire clk,
	input wire srst,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (srst) begin
			meta_reg <= {W{1'b1}};
			sync_reg <= {W{1'b1}};
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule // sync2

// ===== half_period_div.v
// Divider giving a one-cycle enable at each half period of the gated clock
`timescale 1ns/1ps
module half_period_div (
	input wire clk,
	input wire srst,
	input wire run,
	input wire restart,
	input wire [15:0] half,
	output reg tick
);
	reg [15:0] cnt_reg;

	always @(posedge clk) begin
		if (srst || restart || !run) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_reg + 16'h0001 >= half) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // half_period_div

// ===== sar_seq.v
// Successive-approximation sequencer with gated clock and result outputs
`timescale 1ns/1ps
`include "sar_seq_consts.vh"

// Notes on behaviour
// - Trigger sets busy, clock runs 17 cycles
// - Trigger trailing edge initialises register and flags
// - MSB trial first, one decision per clock
// - Busy clears after last decision
// - Busy low forces gated clock low
// - Data outputs change only on gated rising edges
// - Results driven negative-true
// - Straight or offset binary, both inverted
// - Parallel data valid 20 ns before busy falls
// - Serial output MSB first, NRZ
// - Serial bit valid soon after rising edge
// - Early stop after bit above chosen output
// - Resolutions 8,10,12,13,14,15 else full 16
// - External mode steps once per trigger pulse
module sar_seq (
	input wire clk,
	input wire srst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg irq,
	input wire convert_start_n,
	input wire comp_keep,
	output reg busy,
	output reg gated_clk,
	output reg [15:0] data_n,
	output reg serial_n
);
	// ****************************************************************
	// States
	// ****************************************************************
	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_ARMED = 2'b01;
	localparam [1:0] S_RUN = 2'b10;
	localparam [1:0] S_TAIL = 2'b11;

	localparam integer LAG_CYC = `BUSY_LAG_CYC;
	localparam integer PMIN_CYC = `PULSE_MIN_CYC;
	localparam integer PMAX_CYC = `PULSE_MAX_CYC;
	localparam [2:0] LAG = LAG_CYC[2:0];
	localparam [7:0] PMIN = PMIN_CYC[7:0];
	localparam [7:0] PMAX = PMAX_CYC[7:0];

	// ****************************************************************
	// Pin synchronisation and trigger edges
	// ****************************************************************
	wire [1:0] pins_s;
	wire trig_s;
	wire comp_s;
	reg trig_d_reg;
	wire trig_fall;
	wire trig_rise;

	sync2 #(.W(2)) u_sync (
		.clk(clk),
		.srst(srst),
		.din({convert_start_n, comp_keep}),
		.dout(pins_s)
	);

	assign trig_s = pins_s[1];
	assign comp_s = pins_s[0];
	assign trig_fall = trig_d_reg & ~trig_s;
	assign trig_rise = ~trig_d_reg & trig_s;

	always @(posedge clk) begin
		if (srst)
			trig_d_reg <= 1'b1;
		else
			trig_d_reg <= trig_s;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg ext_mode_reg;
	reg [4:0] res_reg;
	reg [15:0] half_reg;
	reg [1:0] status_reg;
	reg [1:0] mask_reg;
	reg [15:0] sar_reg;
	reg [15:0] sar_next;
	reg [1:0] state_reg;
	reg [4:0] step_reg;
	reg [2:0] lag_reg;
	reg [7:0] width_reg;
	reg done_ev;
	reg width_ev;
	wire wr_acc;
	wire div_tick;
	wire rise_step;
	reg div_restart;

	// Request accepted in the cycle waitrequest is low
	assign wr_acc = avs_write & ~avs_waitrequest;

	// Unlisted resolutions fall back to full
	function [4:0] legal_res;
		input [4:0] r;
		begin
			case (r)
				5'h08, 5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h0F: legal_res = r;
				default: legal_res = `RES_FULL;
			endcase
		end
	endfunction

	always @(posedge clk) begin
		if (srst) begin
			ext_mode_reg <= 1'b0;
			res_reg <= `RES_FULL;
			half_reg <= `CLKDIV_RST;
			mask_reg <= 2'b00;
		end else if (wr_acc) begin
			case (avs_address)
				`OFS_CTRL: begin
					if (avs_byteenable[0])
						ext_mode_reg <= avs_writedata[`CTRL_EXT_BIT];
					if (avs_byteenable[1])
						res_reg <= legal_res(
							avs_writedata[`CTRL_RES_MSB:`CTRL_RES_LSB]);
				end
				`OFS_CLKDIV: begin
					// Zero would make the divider tick every cycle
					if (avs_byteenable[1:0] == 2'b11 &&
						avs_writedata[15:0] != 16'h0000)
						half_reg <= avs_writedata[15:0];
				end
				`OFS_MASK: begin
					if (avs_byteenable[0])
						mask_reg <= avs_writedata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky events; a new event wins over a write-one clear
	always @(posedge clk) begin
		if (srst) begin
			status_reg <= 2'b00;
		end else begin
			if (wr_acc && avs_address == `OFS_STATUS && avs_byteenable[0])
				status_reg <= (status_reg & ~avs_writedata[1:0]) |
					{width_ev, done_ev};
			else
				status_reg <= status_reg | {width_ev, done_ev};
		end
	end

	always @(posedge clk) begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(status_reg & mask_reg);
	end

	// ****************************************************************
	// Avalon-MM slave: one wait cycle, then answer
	// ****************************************************************
	always @(posedge clk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if ((avs_read | avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			if (avs_read) begin
				case (avs_address)
					`OFS_CTRL: avs_readdata <= {19'h0_0000, res_reg,
						7'h00, ext_mode_reg};
					`OFS_CLKDIV: avs_readdata <= {16'h0000, half_reg};
					`OFS_STATUS: avs_readdata <= {30'h0000_0000, status_reg};
					`OFS_MASK: avs_readdata <= {30'h0000_0000, mask_reg};
					`OFS_RESULT: avs_readdata <= {15'h0000, busy, ~data_n};
					default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ****************************************************************
	// Gated clock timing
	// ****************************************************************
	half_period_div u_div (
		.clk(clk),
		.srst(srst),
		.run(state_reg == S_RUN && !ext_mode_reg),
		.restart(div_restart),
		.half(half_reg),
		.tick(div_tick)
	);

	// Internal mode steps on every second divider tick
	// External mode steps on each pulse end
	assign rise_step = (state_reg == S_RUN) &&
		(ext_mode_reg ? trig_rise : (div_tick && !gated_clk));

	// Pulse width check on the trigger input
	always @(posedge clk) begin
		if (srst) begin
			width_reg <= 8'h00;
			width_ev <= 1'b0;
		end else begin
			width_ev <= 1'b0;
			if (!trig_s) begin
				if (width_reg != 8'hFF)
					width_reg <= width_reg + 8'h01;
			end else begin
				width_reg <= 8'h00;
				if (trig_rise && (width_reg < PMIN || width_reg > PMAX))
					width_ev <= 1'b1;
			end
		end
	end

	// Keep or drop current trial, try next lower
	always @* begin
		sar_next = sar_reg & ~(`SAR_INIT >> step_reg);
		if (comp_s)
			sar_next = sar_next | (`SAR_INIT >> step_reg);
		if (step_reg < 5'h0F)
			sar_next = sar_next | (`SAR_INIT >> (step_reg + 5'h01));
	end

	// ****************************************************************
	// Conversion sequencer
	// ****************************************************************
	always @(posedge clk) begin
		if (srst) begin
			state_reg <= S_IDLE;
			step_reg <= 5'h00;
			lag_reg <= 3'h0;
			sar_reg <= 16'h0000;
			busy <= 1'b0;
			gated_clk <= 1'b0;
			data_n <= `DATA_N_RST;
			serial_n <= 1'b1;
			done_ev <= 1'b0;
			div_restart <= 1'b0;
		end else begin
			done_ev <= 1'b0;
			div_restart <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (trig_fall) begin
						busy <= 1'b1;
						state_reg <= S_ARMED;
					end
				end
				S_ARMED: begin
					// Trailing edge initialises, clock starts at t0
					if (trig_rise) begin
						sar_reg <= `SAR_INIT;
						step_reg <= 5'h00;
						// Outputs change on this rising edge
						data_n <= ~`SAR_INIT;
						gated_clk <= 1'b1;
						div_restart <= 1'b1;
						state_reg <= S_RUN;
					end
				end
				S_RUN: begin
					if (rise_step) begin
						gated_clk <= 1'b1;
						sar_reg <= sar_next;
						step_reg <= step_reg + 5'h01;
						// Coding set by analog scaling, same logic
						data_n <= ~sar_next;
						// Each decided bit goes out, MSB first
						// Updated right at the rising edge
						serial_n <= ~comp_s;
						// Early stop after chosen bit count
						if (step_reg + 5'h01 >= res_reg) begin
							lag_reg <= 3'h0;
							state_reg <= S_TAIL;
						end
					end else if (ext_mode_reg ? trig_fall :
						(div_tick && gated_clk)) begin
						gated_clk <= 1'b0;
					end
				end
				S_TAIL: begin
					if (ext_mode_reg ? trig_fall : div_tick)
						gated_clk <= 1'b0;
					if (lag_reg + 3'h1 >= LAG) begin
						busy <= 1'b0;
						// Clock held low until next trigger
						gated_clk <= 1'b0;
						done_ev <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						lag_reg <= lag_reg + 3'h1;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule // sar_seq

// ===== sar_seq_checker_assertions.sv
// Checker for the sequencer pins and bus handshake
`timescale 1ns/1ps
module sar_seq_checker (
	input wire clk,
	input wire srst,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire convert_start_n,
	input wire busy,
	input wire gated_clk,
	input wire [15:0] data_n,
	input wire serial_n
);
// ****
// Gated clock rises since busy rose
// ****
reg [4:0] rises_reg;
reg gclk_reg;
always @(posedge clk) begin
	gclk_reg <= gated_clk;
	if (srst || !busy)
		rises_reg <= 5'h0;
	else if (gated_clk && !gclk_reg)
		rises_reg <= rises_reg + 5'h1;
end
default clocking dc @(posedge clk); endclocking
default disable iff (srst);
a_idle_clk_low: assert property (!busy |-> !gated_clk)
	else $error("gated clock high while idle");
a_data_on_rise: assert property ($changed(data_n) |-> $rose(gated_clk))
	else $error("parallel data changed off a rise");
a_serial_on_rise: assert property ($changed(serial_n) |-> $rose(gated_clk))
	else $error("serial data changed off a rise");
a_data_before_fall: assert property
	($fell(busy) |-> $stable(data_n) && $past(data_n, 4) == data_n)
	else $error("data not settled before busy fell");
a_step_count: assert property
	($fell(busy) |-> rises_reg >= 5'd9 && rises_reg <= 5'd17)
	else $error("wrong number of clock rises");
a_first_trial: assert property
	($rose(gated_clk) && rises_reg == 5'h0 |-> data_n == 16'h7FFF)
	else $error("first trial word wrong");
a_trailing_start: assert property
	(busy && rises_reg == 5'h0 && $rose(convert_start_n)
	|-> ##[2:4] $rose(gated_clk))
	else $error("no first rise after trailing edge");
a_busy_cause: assert property ($rose(busy) |-> !$past(convert_start_n, 2))
	else $error("busy rose without a trigger");
a_bus_answer: assert property
	((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
	else $error("bus request not answered");
c_done: cover property ($fell(busy));
c_full: cover property ($fell(busy) && rises_reg == 5'd17);
c_read: cover property (avs_read && !avs_waitrequest);
endmodule // sar_seq_checker
bind sar_seq sar_seq_checker u_chk (.clk(clk), .srst(srst),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .convert_start_n(convert_start_n),
	.busy(busy), .gated_clk(gated_clk), .data_n(data_n),
	.serial_n(serial_n));

// ===== result_catcher.sv
// Host logic capturing parallel and serial results
`timescale 1ns/1ps
module result_catcher (
	input wire clk,
	input wire busy,
	input wire gated_clk,
	input wire serial_n,
	input wire [15:0] data_n,
	output reg [15:0] par_word,
	output reg [15:0] ser_word,
	output reg [15:0] inverted_twos_complement
);
reg busy_q = 1'b0;
reg gclk_q = 1'b0;
always @(posedge clk) begin
	busy_q <= busy;
	gclk_q <= gated_clk;
	if (busy_q && !busy) begin
		par_word <= data_n;
		// flip only the MSB for twos complement
		inverted_twos_complement <= data_n ^ 16'h8000;
	end
	if (gclk_q && !gated_clk)
		ser_word <= {ser_word[14:0], serial_n};
end
endmodule // result_catcher

// ===== sar_adc_sequencer_output_bench.sv
// Bench for conversions, registers and interrupt of the sequencer
`timescale 1ns/1ps
`include "sar_seq_consts.vh"
module sar_adc_sequencer_output_bench;
reg clk = 0, srst = 1, avs_read = 0, avs_write = 0;
reg convert_start_n = 1, comp_keep = 0;
reg [7:0] avs_address = 0;
reg [31:0] avs_writedata = 0, q;
reg [15:0] target = 0, m, e, t, v;
reg [4:0] res_t [0:7];
reg [15:0] tgt_t [0:7];
wire [31:0] avs_readdata;
wire avs_waitrequest, irq, busy, gated_clk, serial_n;
wire [15:0] data_n, par_word, ser_word, inverted_twos_complement;
integer n_errors = 0, total_checks = 0, i, r, n;
always #2.5 clk = ~clk;
// Comparator: keep the trial bit while the trial word is not above target
always @(posedge clk) comp_keep <= (~data_n <= target);
sar_seq u_dut (.clk(clk), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.irq(irq), .convert_start_n(convert_start_n), .comp_keep(comp_keep),
	.busy(busy), .gated_clk(gated_clk), .data_n(data_n),
	.serial_n(serial_n));
result_catcher u_host (.clk(clk), .busy(busy), .gated_clk(gated_clk),
	.serial_n(serial_n), .data_n(data_n), .par_word(par_word),
	.ser_word(ser_word),
	.inverted_twos_complement(inverted_twos_complement));
task chk(input [31:0] g, input [31:0] x); begin
	total_checks = total_checks + 1;
	if (g !== x) begin
		n_errors = n_errors + 1;
		$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
	end
end endtask
task bus(input w, input [7:0] a, input [31:0] d); begin
	@(posedge clk);
	avs_address <= a;
	avs_write <= w;
	avs_read <= !w;
	avs_writedata <= d;
	n = 0;
	@(posedge clk);
	while (avs_waitrequest !== 1'b0 && n < 50) begin
		n = n + 1;
		@(posedge clk);
	end
	if (n >= 50) n_errors = n_errors + 1;
	q = avs_readdata;
	avs_read <= 0;
	avs_write <= 0;
end endtask
task pulse(input integer lo); begin
	@(posedge clk) convert_start_n <= 0;
	repeat (lo) @(posedge clk);
	chk(busy, 1);
	convert_start_n <= 1;
end endtask
task convert(input integer lo); begin
	pulse(lo);
	n = 0;
	@(posedge clk);
	while (busy !== 1'b0 && n < 2000) begin
		n = n + 1;
		@(posedge clk);
	end
	if (n >= 2000) n_errors = n_errors + 1;
	repeat (3) @(posedge clk);
end endtask
task tally_and_finish; begin
	$display("checks %0d mismatches %0d", total_checks, n_errors);
	if (n_errors == 0 && total_checks > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
end endtask
// Watchdog: whole run needs about 2200 cycles
initial begin
	#50000;
	chk(0, 1);
	tally_and_finish;
end
initial begin
	{res_t[0], tgt_t[0]} = {5'd16, 16'hA5C3};
	{res_t[1], tgt_t[1]} = {5'd15, 16'h5A3C};
	{res_t[2], tgt_t[2]} = {5'd14, 16'hFFFF};
	{res_t[3], tgt_t[3]} = {5'd13, 16'h0001};
	{res_t[4], tgt_t[4]} = {5'd12, 16'h8000};
	{res_t[5], tgt_t[5]} = {5'd10, 16'h7FFF};
	{res_t[6], tgt_t[6]} = {5'd8, 16'h1234};
	{res_t[7], tgt_t[7]} = {5'd9, 16'hC0DE};
	repeat (10) @(posedge clk);
	srst <= 0;
	bus(0, `OFS_CTRL, 0);
	chk(q, 32'h0000_1000);
	bus(0, `OFS_CLKDIV, 0);
	chk(q, 32'h0000_006B);
	chk(data_n, 16'hFFFF);
	bus(0, 8'h20, 0);
	chk(q, 0);
	bus(1, `OFS_CLKDIV, 32'h0000_0004);
	$display("register test done");
	for (i = 0; i < 8; i = i + 1) begin
		target <= tgt_t[i];
		bus(1, `OFS_CTRL, {19'h0, res_t[i], 8'h00});
		convert(40);
		r = (res_t[i] == 5'd9) ? 16 : res_t[i];
		m = 16'hFFFF << (16 - r);
		// Early stop leaves the next lower trial bit set
		t = (r < 16) ? (16'h8000 >> r) : 16'h0000;
		e = ~((tgt_t[i] & m) | t);
		v = ((tgt_t[i] & m) | t) - 16'h8000;
		chk(data_n, e);
		chk(par_word, e);
		chk(inverted_twos_complement, {16'h0000, ~v});
		chk(ser_word & ~(16'hFFFF << r), e >> (16 - r));
		bus(0, `OFS_RESULT, 0);
		chk(q, {16'h0, (tgt_t[i] & m) | t});
		chk(irq, 0);
		bus(1, `OFS_STATUS, 32'h0000_0003);
		$display("row %0d done", i);
	end
	bus(1, `OFS_MASK, 32'h0000_0001);
	convert(40);
	chk(irq, 1);
	bus(0, `OFS_STATUS, 0);
	chk(q[0], 1);
	bus(1, `OFS_STATUS, 32'h0000_0001);
	repeat (2) @(posedge clk);
	chk(irq, 0);
	$display("interrupt test done");
	target <= 16'h3C5A;
	bus(1, `OFS_CTRL, 32'h0000_0801);
	for (i = 0; i < 9; i = i + 1) begin
		pulse(30);
		repeat (30) @(posedge clk);
	end
	chk(busy, 0);
	chk(data_n, 16'hC37F);
	chk(ser_word & 16'h00FF, 16'h00C3);
	bus(0, `OFS_STATUS, 0);
	chk(q, 32'h0000_0001);
	bus(1, `OFS_STATUS, 32'h0000_0003);
	$display("external clock test done");
	bus(1, `OFS_CTRL, 32'h0000_0800);
	convert(10);
	bus(0, `OFS_STATUS, 0);
	chk(q, 32'h0000_0003);
	bus(1, `OFS_STATUS, 32'h0000_0003);
	$display("pulse width test done");
	@(posedge clk) convert_start_n <= 0;
	repeat (20) @(posedge clk);
	srst <= 1;
	convert_start_n <= 1;
	repeat (3) @(posedge clk);
	srst <= 0;
	@(posedge clk);
	chk(busy, 0);
	chk(gated_clk, 0);
	chk(serial_n, 1);
	chk(avs_waitrequest, 1);
	chk(data_n, 16'hFFFF);
	$display("reset test done");
	tally_and_finish;
end
endmodule // sar_adc_sequencer_output_bench
